// ### core/ctr_accumulator.sv
/*
 * Counter module: control, frequency and phase registers, mode decode,
 * conditional 32-bit accumulation, pin output and direction gating, and a
 * divided PLL tap model. Assumes the processor addresses registers through
 * a simple instruction port: wr_en/wr_sel/wr_data and a source-read mux.
 */
// Behaviour
// - accumulate freq_inc when mode condition true
// - instruction write overrides same-cycle accumulation
// - live phase seen only as source operand
// - destination reads use last-written shadow value
// - PLL modes always accumulate, drive pll_out
// - NCO/duty modes output bit 31/carry
// - positive level detect on A1, feedback
// - rising edge A1&!A2, feedback on pin_b
// - negative level detect on !A1, feedback
// - falling edge !A1&A2, feedback on pin_b
// - logic modes 16-23 accumulate listed functions
// - logic modes 24-31 accumulate listed functions
// - A delayed one/two clocks, B one
// - outputs reach pin only when direction set
// - control write immediate; zero stops all
// - control field layout mode/div/pinb/pina
// - bit 31 feeds PLL; div selects tap
`timescale 1ns/1ps
`include "ctr_map.svh"
module ctr_accumulator #(
    parameter int PINS = 64
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire ctr_pkg::reg_sel_t wr_sel,
    input wire logic [31:0] wr_data,
    input wire ctr_pkg::reg_sel_t rd_sel,
    input wire logic rd_is_dest,
    input wire logic [PINS-1:0] pins_in,
    input wire logic [PINS-1:0] pin_dir,
    input wire logic vco_clk_en,
    output logic [31:0] rd_data,
    output logic [PINS-1:0] pins_out,
    output logic pll_ref,
    output logic pll_out
);
    ctr_samp_if samp ();

    ctr_pkg::word_t ctl_reg, ctl_next;
    ctr_pkg::word_t freq_reg, freq_next;
    ctr_pkg::word_t phase_reg, phase_next;
    ctr_pkg::word_t shadow_reg, shadow_next;
    ctr_pkg::word_t rd_reg, rd_next;
    logic [PINS-1:0] pout_reg, pout_next;
    logic ref_reg, ref_next;
    logic pll_reg, pll_next;
    logic [6:0] vco_div_reg, vco_div_next;

    ctr_pkg::mode_t mode;
    logic [2:0] div_sel;
    logic [5:0] idx_a, idx_b;
    logic [32:0] sum;
    logic carry;
    logic acc_cond;
    logic out_a, out_b;

    ////////////////////////////////////////////////////////////////////////////
    // control field decode
    function automatic ctr_pkg::mode_t mode_of(input ctr_pkg::word_t c);
        return c[`CTL_MODE_HI:`CTL_MODE_LO];
    endfunction : mode_of

    assign mode = mode_of(ctl_reg);
    assign div_sel = ctl_reg[`CTL_DIV_HI:`CTL_DIV_LO];
    assign idx_b = ctl_reg[`CTL_PINB_HI:`CTL_PINB_LO];
    assign idx_a = ctl_reg[`CTL_PINA_HI:`CTL_PINA_LO];

    ctr_pin_sampler #(.PINS(PINS)) u_samp (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pins_in(pins_in),
        .sel_a(idx_a),
        .sel_b(idx_b),
        .samp(samp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // 33-bit sum gives the wrapped value and the carry out of bit 31
    assign sum = {1'b0, phase_reg} + {1'b0, freq_reg};
    assign carry = sum[32];

    // accumulate condition and pin functions for each mode
    always_comb begin
        logic a, a2, b;
        a = samp.a1;
        a2 = samp.a2;
        b = samp.b1;
        acc_cond = 1'b0;
        out_a = 1'b0;
        out_b = 1'b0;
        if (mode[4]) begin
            // logic modes: the low four bits form a truth table over A,B
            // indexed {B,A}; bit0=!A!B, bit1=A!B, bit2=!AB, bit3=AB
            acc_cond = mode[{b, a}];
        end else begin
            unique case (mode[3:0])
                4'h0: acc_cond = 1'b0;
                4'h1: acc_cond = 1'b1;
                4'h2: begin
                    acc_cond = 1'b1;
                    out_a = pll_reg;
                end
                4'h3: begin
                    acc_cond = 1'b1;
                    out_a = pll_reg;
                    out_b = ~pll_reg;
                end
                4'h4, 4'h5: begin
                    acc_cond = 1'b1;
                    out_a = phase_reg[31];
                    out_b = mode[0] & ~phase_reg[31];
                end
                4'h6, 4'h7: begin
                    acc_cond = 1'b1;
                    out_a = carry;
                    out_b = mode[0] & ~carry;
                end
                4'h8, 4'h9: acc_cond = a;
                4'hA, 4'hB: acc_cond = a & ~a2;
                4'hC, 4'hD: acc_cond = ~a;
                4'hE, 4'hF: acc_cond = ~a & a2;
            endcase
            if (mode[3]) begin
                out_b = mode[0] & ~a;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register next values: a write beats accumulation in the same cycle
    always_comb begin
        ctl_next = ctl_reg;
        freq_next = freq_reg;
        shadow_next = shadow_reg;
        phase_next = acc_cond ? sum[31:0] : phase_reg;
        if (wr_en) begin
            unique case (wr_sel)
                ctr_pkg::SEL_CTL: ctl_next = wr_data;
                ctr_pkg::SEL_FREQ: freq_next = wr_data;
                ctr_pkg::SEL_PHASE: begin
                    phase_next = wr_data;
                    shadow_next = wr_data;
                end
                default: ;
            endcase
        end
    end

    // read mux: destination sees the shadow, source sees the live count
    always_comb begin
        unique case (rd_sel)
            ctr_pkg::SEL_CTL: rd_next = ctl_reg;
            ctr_pkg::SEL_FREQ: rd_next = freq_reg;
            ctr_pkg::SEL_PHASE: rd_next = rd_is_dest ? shadow_reg : phase_reg;
            default: rd_next = 32'h00000000;
        endcase
    end

    // pin drive: a counter output only reaches a pin set to output
    always_comb begin
        pout_next = '0;
        for (int i = 0; i < PINS; i++) begin
            pout_next[i] = pin_dir[i] & ((out_a & (32'(idx_a) == i)) |
                                         (out_b & (32'(idx_b) == i)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PLL model: phase bit 31 is the reference; a vco_clk_en pulse stands in
    // for each VCO edge (16x reference, analog part lives outside), and the
    // divider picks a tap from /128 up to /1. The tap toggles on each edge
    // of the selected counter bit, so it is a digital stand-in only.
    always_comb begin
        logic [6:0] mask;
        mask = 7'((8'h80 >> div_sel) - 8'h01); // 2^(7-div)-1 low counter bits
        ref_next = phase_reg[31];
        vco_div_next = vco_clk_en ? vco_div_reg + 7'h01 : vco_div_reg;
        pll_next = pll_reg;
        if (mode == `MODE_OFF) begin
            pll_next = 1'b0;
        end else if (vco_clk_en && ((vco_div_reg & mask) == mask)) begin
            // toggle once per 2^(7-div) VCO edges: /128 .. /1
            pll_next = ~pll_reg;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_reg <= `CTL_RESET;
            freq_reg <= `FREQ_RESET;
            phase_reg <= `PHASE_RESET;
            shadow_reg <= `PHASE_RESET;
            rd_reg <= 32'h00000000;
            pout_reg <= '0;
            ref_reg <= 1'b0;
            pll_reg <= 1'b0;
            vco_div_reg <= 7'h00;
        end else if (clk_en) begin
            ctl_reg <= ctl_next;
            freq_reg <= freq_next;
            phase_reg <= phase_next;
            shadow_reg <= shadow_next;
            rd_reg <= rd_next;
            pout_reg <= pout_next;
            ref_reg <= ref_next;
            pll_reg <= pll_next;
            vco_div_reg <= vco_div_next;
        end
    end

    assign rd_data = rd_reg;
    assign pins_out = pout_reg;
    assign pll_ref = ref_reg;
    assign pll_out = pll_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_acc_adds_freq: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && acc_cond && !wr_en |=> phase_reg == $past(sum[31:0]))
        else $error("phase did not add frequency");
    a_acc_holds: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !acc_cond && !wr_en |=> $stable(phase_reg))
        else $error("phase moved without condition");
    a_write_wins: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_en && wr_sel == ctr_pkg::SEL_PHASE |=> phase_reg == $past(wr_data))
        else $error("phase write lost to accumulation");
    a_dest_shadow: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && rd_sel == ctr_pkg::SEL_PHASE && rd_is_dest |=>
        rd_data == $past(shadow_reg))
        else $error("destination read saw live phase");
    a_shadow_last: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !(wr_en && wr_sel == ctr_pkg::SEL_PHASE) |=> $stable(shadow_reg))
        else $error("shadow changed without a write");
    a_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode == `MODE_OFF |-> !acc_cond && !out_a && !out_b)
        else $error("off mode still active");
    a_pll_always: assert property (@(posedge clk) disable iff (!reset_n)
        mode inside {[5'h01:5'h07], 5'h1F} |-> acc_cond)
        else $error("always-accumulate mode idle");
    a_posedge_cnt: assert property (@(posedge clk) disable iff (!reset_n)
        mode == `MODE_POSEDGE |-> acc_cond == (samp.a1 && !samp.a2))
        else $error("rising edge condition wrong");
    a_negedge_cnt: assert property (@(posedge clk) disable iff (!reset_n)
        mode == `MODE_NEGEDGE_FB |-> acc_cond == (!samp.a1 && samp.a2) && out_b == !samp.a1)
        else $error("falling edge condition wrong");
    a_dir_gate: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en |=> (pins_out & ~$past(pin_dir)) == '0)
        else $error("pin driven while input");
    a_logic_xor: assert property (@(posedge clk) disable iff (!reset_n)
        mode == 5'h16 |-> acc_cond == (samp.a1 ^ samp.b1))
        else $error("xor logic mode wrong");
    a_logic_anb: assert property (@(posedge clk) disable iff (!reset_n)
        mode == 5'h12 |-> acc_cond == (samp.a1 && !samp.b1))
        else $error("a-and-not-b logic mode wrong");
    a_logic_eq: assert property (@(posedge clk) disable iff (!reset_n)
        mode == 5'h19 |-> acc_cond == (samp.a1 == samp.b1) && !out_a)
        else $error("equal logic mode wrong");
    a_neg_level: assert property (@(posedge clk) disable iff (!reset_n)
        mode == `MODE_NEG_FB |-> acc_cond == !samp.a1)
        else $error("negative level wrong");
    a_pos_level: assert property (@(posedge clk) disable iff (!reset_n)
        mode == `MODE_POS_FB |-> acc_cond == samp.a1 && out_b == !samp.a1)
        else $error("positive level wrong");
    a_duty_carry: assert property (@(posedge clk) disable iff (!reset_n)
        mode == `MODE_DUTY_DIFF |-> out_a == carry && out_b == !carry)
        else $error("duty output wrong");
    a_pll_ref: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en |=> pll_ref == $past(phase_reg[31]))
        else $error("pll reference not bit 31");
endmodule : ctr_accumulator

// ### core/ctr_map.svh
/*
 * Register layout, field positions, mode codes and PLL constants for
 * the counter accumulator. Assumes inclusion by bare name from core/.
 */
`ifndef CTR_MAP_SVH
`define CTR_MAP_SVH

// control word field positions
`define CTL_MODE_HI 30
`define CTL_MODE_LO 26
`define CTL_DIV_HI 25
`define CTL_DIV_LO 23
`define CTL_PINB_HI 14
`define CTL_PINB_LO 9
`define CTL_PINA_HI 5
`define CTL_PINA_LO 0

// reset values
`define CTL_RESET 32'h00000000
`define PHASE_RESET 32'h00000000
`define FREQ_RESET 32'h00000000

// mode codes (full 5-bit values of the mode field)
`define MODE_OFF 5'h00
`define MODE_PLL_INT 5'h01
`define MODE_PLL_SE 5'h02
`define MODE_PLL_DIFF 5'h03
`define MODE_NCO_SE 5'h04
`define MODE_NCO_DIFF 5'h05
`define MODE_DUTY_SE 5'h06
`define MODE_DUTY_DIFF 5'h07
`define MODE_POS 5'h08
`define MODE_POS_FB 5'h09
`define MODE_POSEDGE 5'h0A
`define MODE_POSEDGE_FB 5'h0B
`define MODE_NEG 5'h0C
`define MODE_NEG_FB 5'h0D
`define MODE_NEGEDGE 5'h0E
`define MODE_NEGEDGE_FB 5'h0F

// pll: reference multiplier and log2 of the largest divider
`define PLL_MULT 16
`define PLL_DIV_MAX_LOG2 7

`endif

// ### core/ctr_pin_sampler.sv
/*
 * Selects pin_a and pin_b from the pin array and delays them: A by one and
 * two clocks, B by one clock. Assumes pins already synchronous to clk.
 */
`timescale 1ns/1ps
`include "ctr_map.svh"
module ctr_pin_sampler #(
    parameter int PINS = 64
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [PINS-1:0] pins_in,
    input wire logic [5:0] sel_a,
    input wire logic [5:0] sel_b,
    ctr_samp_if.src samp
);
    logic a1_reg, a2_reg, b1_reg;
    logic a1_next, a2_next, b1_next;

    ////////////////////////////////////////////////////////////////////////////
    // delay line next values; an out-of-range index reads low
    always_comb begin
        a1_next = (32'(sel_a) < PINS) ? pins_in[sel_a] : 1'b0;
        a2_next = a1_reg;
        b1_next = (32'(sel_b) < PINS) ? pins_in[sel_b] : 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            a1_reg <= 1'b0;
            a2_reg <= 1'b0;
            b1_reg <= 1'b0;
        end else if (clk_en) begin
            a1_reg <= a1_next;
            a2_reg <= a2_next;
            b1_reg <= b1_next;
        end
    end

    assign samp.a1 = a1_reg;
    assign samp.a2 = a2_reg;
    assign samp.b1 = b1_reg;

    a_two_clk_delay: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en |=> a2_reg == $past(a1_reg))
        else $error("second A sample is not the first delayed");
endmodule : ctr_pin_sampler

// ### core/ctr_pkg.sv
/*
 * Types for the counter accumulator. Assumes ctr_map.svh is compiled with it.
 */
package ctr_pkg;
    typedef logic [4:0] mode_t;
    typedef logic [31:0] word_t;
    // register select for the instruction port
    typedef enum logic [1:0] {
        SEL_CTL = 2'h0,
        SEL_FREQ = 2'h1,
        SEL_PHASE = 2'h2
    } reg_sel_t;
endpackage : ctr_pkg

// ### core/ctr_samp_if.sv
/*
 * Carrier of the delayed pin samples from the sampler to the counter core.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface ctr_samp_if;
    logic a1;
    logic a2;
    logic b1;
    modport src (output a1, output a2, output b1);
    modport dst (input a1, input a2, input b1);
endinterface : ctr_samp_if

// ### verif/pin_world.sv
/*
 * Outside world at the counter's pins.
 * Assumes the bench commands the levels seen on the two chosen pins.
 */
`timescale 1ns/1ps
module pin_world #(
    parameter int PINS = 64
) (
    input wire logic clk,
    input wire logic [PINS-1:0] pins_out,
    input wire logic [PINS-1:0] pin_dir,
    input wire logic [5:0] idx_a,
    input wire logic [5:0] idx_b,
    input wire logic lvl_a,
    input wire logic lvl_b,
    output logic [PINS-1:0] pins_in
);
    logic noise_reg = 1'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // undriven pins wander, so a stale level never passes for a real one
    always @(negedge clk) begin
        noise_reg <= ~noise_reg;
    end

    // an output pin shows the counter's drive, any other the outside level
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (pin_dir[i])
                pins_in[i] = pins_out[i];
            else if (i == int'(idx_a))
                pins_in[i] = lvl_a;
            else if (i == int'(idx_b))
                pins_in[i] = lvl_b;
            else
                pins_in[i] = noise_reg ^ i[0];
        end
    end
endmodule : pin_world

// ### verif/tb.sv
/*
 * Self-checking bench for the counter accumulator.
 * Assumes ctr_pkg, the design files and pin_world are compiled first.
 */
`timescale 1ns/1ps
`include "ctr_map.svh"
module tb;
    localparam int PINS = 64;
    localparam logic [5:0] PA = 6'h03;
    localparam logic [5:0] PB = 6'h05;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic clk_en = 1'h1;
    logic wr_en = 1'h0;
    logic rd_is_dest = 1'h0;
    logic vco_clk_en = 1'h0;
    logic lvl_a = 1'h0;
    logic lvl_b = 1'h0;
    ctr_pkg::reg_sel_t wr_sel = ctr_pkg::SEL_CTL;
    ctr_pkg::reg_sel_t rd_sel = ctr_pkg::SEL_CTL;
    logic [31:0] wr_data = 32'h00000000;
    logic [31:0] rd_data;
    logic [PINS-1:0] pins_in;
    logic [PINS-1:0] pins_out;
    logic [PINS-1:0] pin_dir = {PINS{1'h0}};
    logic pll_ref;
    logic pll_out;
    int err_count = 0;
    int comparisons = 0;

    ctr_accumulator #(.PINS(PINS)) ctr_accumulator_inst (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .wr_en(wr_en),
        .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel),
        .rd_is_dest(rd_is_dest), .pins_in(pins_in), .pin_dir(pin_dir),
        .vco_clk_en(vco_clk_en), .rd_data(rd_data), .pins_out(pins_out),
        .pll_ref(pll_ref), .pll_out(pll_out)
    );
    pin_world #(.PINS(PINS)) pin_world_inst (
        .clk(clk), .pins_out(pins_out), .pin_dir(pin_dir), .idx_a(PA),
        .idx_b(PB), .lvl_a(lvl_a), .lvl_b(lvl_b), .pins_in(pins_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock, and a vco stand-in pulsing every other cycle
    initial begin
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        vco_clk_en <= ~vco_clk_en;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control word: mode, divide-by-one tap, fixed pin indices
    function automatic logic [31:0] ctl(input logic [4:0] m);
        return {1'h0, m, 3'h7, 8'h00, PB, 3'h0, PA};
    endfunction : ctl

    // expected accumulate condition for steady pin levels
    function automatic logic acc_cond(input logic [4:0] m, input logic a, input logic b);
        if (m[4])
            return m[{b, a}];
        if (m[3:1] == 3'h4)
            return a;
        if (m[3:1] == 3'h6)
            return !a;
        return 1'h0;
    endfunction : acc_cond

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // write strobe held one cycle, then a gap so it is never re-raised at once
    task automatic wr(input ctr_pkg::reg_sel_t sel, input logic [31:0] d);
        wr_en = 1'h1;
        wr_sel = sel;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'h0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input ctr_pkg::reg_sel_t sel, input logic dest, output logic [31:0] d);
        rd_sel = sel;
        rd_is_dest = dest;
        @(negedge clk);
        d = rd_data;
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] v;
        rd(ctr_pkg::SEL_CTL, 1'h0, v);
        check("ctl_reset", `CTL_RESET, v);
        rd(ctr_pkg::SEL_FREQ, 1'h0, v);
        check("freq_reset", `FREQ_RESET, v);
        rd(ctr_pkg::SEL_PHASE, 1'h0, v);
        check("phase_reset", `PHASE_RESET, v);
        check("pins_reset", 32'h00000000, pins_out[31:0]);
    endtask : t_reset

    // free-running add with wrap, write override and shadow reads
    task automatic t_always;
        logic [31:0] p0;
        logic [31:0] p1;
        logic hit;
        wr(ctr_pkg::SEL_FREQ, 32'h90000001);
        wr(ctr_pkg::SEL_PHASE, 32'hA5A5A5A5);
        rd(ctr_pkg::SEL_PHASE, 1'h0, p0);
        check("phase_off", 32'hA5A5A5A5, p0);
        wr(ctr_pkg::SEL_CTL, ctl(5'h1F));
        rd(ctr_pkg::SEL_PHASE, 1'h0, p0);
        rd(ctr_pkg::SEL_PHASE, 1'h0, p1);
        check("phase_step", 32'h90000001, p1 - p0);
        rd(ctr_pkg::SEL_PHASE, 1'h1, p1);
        check("phase_shadow", 32'hA5A5A5A5, p1);
        wr(ctr_pkg::SEL_PHASE, 32'h00000100);
        rd(ctr_pkg::SEL_PHASE, 1'h0, p0);
        hit = 1'h0;
        for (int k = 0; k < 4; k++) begin
            if (p0 === 32'h00000100 + k * 32'h90000001)
                hit = 1'h1;
        end
        check("phase_override", 32'h00000001, {31'h0, hit});
        rd(ctr_pkg::SEL_PHASE, 1'h1, p1);
        check("shadow_written", 32'h00000100, p1);
        rd(ctr_pkg::SEL_PHASE, 1'h0, p0);
        clk_en = 1'h0;
        repeat (3) @(negedge clk);
        clk_en = 1'h1;
        rd(ctr_pkg::SEL_PHASE, 1'h0, p1);
        check("clk_en_freeze", 32'h90000001, p1 - p0);
        wr(ctr_pkg::SEL_CTL, 32'h00000000);
        rd(ctr_pkg::SEL_PHASE, 1'h0, p0);
        repeat (3) @(negedge clk);
        rd(ctr_pkg::SEL_PHASE, 1'h0, p1);
        check("phase_stopped", 32'h00000000, p1 - p0);
    endtask : t_always

    // every detector and logic mode against all four steady pin pairs
    task automatic t_levels;
        logic [31:0] v;
        logic [4:0] m;
        wr(ctr_pkg::SEL_FREQ, 32'h00000001);
        for (int i = 8; i < 32; i++) begin
            for (int ab = 0; ab < 4; ab++) begin
                m = 5'(i);
                lvl_a = ab[0];
                lvl_b = ab[1];
                repeat (3) @(negedge clk);
                wr(ctr_pkg::SEL_CTL, ctl(m));
                wr(ctr_pkg::SEL_PHASE, 32'h00000000);
                repeat (4) @(negedge clk);
                wr(ctr_pkg::SEL_CTL, 32'h00000000);
                rd(ctr_pkg::SEL_PHASE, 1'h0, v);
                check("acc_cond", {31'h0, acc_cond(m, ab[0], ab[1])}, {31'h0, |v});
            end
        end
    endtask : t_levels

    // three pulses on pin_a must count exactly three edges
    task automatic t_edges;
        logic [31:0] v;
        logic s;
        logic [4:0] modes [4] = '{5'h0A, 5'h0B, 5'h0E, 5'h0F};
        foreach (modes[j]) begin
            s = modes[j][2];
            lvl_a = s;
            repeat (3) @(negedge clk);
            wr(ctr_pkg::SEL_CTL, ctl(modes[j]));
            wr(ctr_pkg::SEL_PHASE, 32'h00000000);
            repeat (3) begin
                repeat (3) @(negedge clk);
                lvl_a = !s;
                repeat (3) @(negedge clk);
                lvl_a = s;
            end
            repeat (3) @(negedge clk);
            wr(ctr_pkg::SEL_CTL, 32'h00000000);
            rd(ctr_pkg::SEL_PHASE, 1'h0, v);
            check("edge_count", 32'h00000003, v);
        end
    endtask : t_edges

    // pin drive of pll, oscillator and duty modes, direction gating, feedback
    task automatic t_outputs;
        logic a;
        logic a0;
        logic rf;
        logic po;
        int flips;
        int rflips;
        int pflips;
        wr(ctr_pkg::SEL_FREQ, 32'h80000000);
        pin_dir[PA] = 1'h1;
        pin_dir[PB] = 1'h1;
        for (int i = 1; i < 8; i++) begin
            wr(ctr_pkg::SEL_CTL, ctl(5'(i)));
            repeat (3) @(negedge clk);
            flips = 0;
            rflips = 0;
            pflips = 0;
            a0 = pins_out[PA];
            rf = pll_ref;
            po = pll_out;
            for (int c = 0; c < 8; c++) begin
                @(negedge clk);
                a = pins_out[PA];
                flips += int'(a !== a0);
                rflips += int'(pll_ref !== rf);
                pflips += int'(pll_out !== po);
                a0 = a;
                rf = pll_ref;
                po = pll_out;
                check("pin_b_drive", {31'h0, (i[0] && i > 1) ? !a : 1'h0}, {31'h0, pins_out[PB]});
                if (i == 1)
                    check("pin_a_internal", 32'h00000000, {31'h0, a});
            end
            if (i >= 4)
                check("pin_a_toggles", 32'h00000001, {31'h0, flips >= 4});
            else
                check("pll_ref_toggles", 32'h00000001, {31'h0, rflips >= 4});
            if (i < 4)
                check("pll_out_toggles", 32'h00000004, 32'(pflips));
        end
        pin_dir[PA] = 1'h0;
        lvl_a = 1'h0;
        repeat (4) @(negedge clk);
        check("pin_a_gated", 32'h00000000, {31'h0, pins_out[PA]});
        wr(ctr_pkg::SEL_CTL, ctl(5'h09));
        repeat (3) @(negedge clk);
        check("feedback_low", 32'h00000001, {31'h0, pins_out[PB]});
        lvl_a = 1'h1;
        repeat (3) @(negedge clk);
        check("feedback_high", 32'h00000000, {31'h0, pins_out[PB]});
        wr(ctr_pkg::SEL_CTL, 32'h00000000);
        repeat (2) @(negedge clk);
        check("pins_off", 32'h00000000, pins_out[31:0]);
    endtask : t_outputs

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // tests take about 1600 cycles; the limit leaves wide margin
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'h1;
        t_reset();
        t_always();
        t_levels();
        t_edges();
        t_outputs();
        end_of_test();
    end
endmodule : tb
